// file: core/vec_params.svh
// register indices, field positions, reset values and line limits of the encoder
// control bank; definitions only
`ifndef VEC_PARAMS_SVH
`define VEC_PARAMS_SVH

`define VEC_IDX_GLOBAL       8'h04
`define VEC_IDX_VIDEO_OUT    8'h05
`define VEC_IDX_ANC_CTRL     8'h06
`define VEC_IDX_ANC_ID       8'h07
`define VEC_IDX_FREQ3        8'h08
`define VEC_IDX_FREQ2        8'h09
`define VEC_IDX_FREQ1        8'h0A
`define VEC_IDX_FREQ0        8'h0B
`define VEC_IDX_PHASE_HI     8'h0C
`define VEC_IDX_PHASE_LO     8'h0D
`define VEC_IDX_PORT_DATA    8'h0E
`define VEC_IDX_PORT_DIR     8'h0F

`define VEC_GLB_LOCK_EN      6
`define VEC_GLB_FMT_HI       1
`define VEC_GLB_FMT_LO       0
`define VEC_FMT_NTSC         2'h0
`define VEC_FMT_PALM         2'h2

`define VEC_VO_CHROMA_BW     5
`define VEC_VO_SYNC_SUP      4
`define VEC_VO_BURST_SUP     3
`define VEC_VO_LUMA_SUP      2
`define VEC_VO_CHROMA_SUP    1
`define VEC_VO_SETUP_EN      0

`define VEC_ANC_LOCK_LOST    6
`define VEC_ANC_FIELD_HI     5
`define VEC_ANC_FIELD_LO     3
`define VEC_ANC_FREQ_EN      2
`define VEC_ANC_PHASE_EN     1
`define VEC_ANC_TIMING_EN    0

`define VEC_RST_BYTE         8'h00
`define VEC_RST_FREQ         32'h43E0F83E

`define VEC_SETUP_A_FIRST    10'h017
`define VEC_SETUP_A_LAST     10'h106
`define VEC_SETUP_B_FIRST    10'h11E
`define VEC_SETUP_B_LAST     10'h20D

`endif

// file: core/vec_pkg.sv
// types shared by the encoder control bank and its surroundings
// assumes nothing beyond a SystemVerilog compiler
package vec_pkg;

    typedef struct packed {
        logic chroma_wide;
        logic sync_drop;
        logic burst_drop;
        logic luma_black;
        logic chroma_zero;
        logic dc_blank;
        logic pedestal_on;
        logic gain_rescale;
    } vec_video_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  id;
        logic [31:0] freq;
        logic        freq_valid;
        logic [15:0] phase;
        logic        phase_valid;
        logic [2:0]  field;
        logic        vflag;
    } vec_anc_pkt_s;

    typedef struct packed {
        logic       use_anc;
        logic [2:0] field;
        logic       vflag;
    } vec_timing_s;

endpackage

// file: core/vec_ctrl_regs.sv
// upper control register bank of the video encoder
// assumes a serial-bus front end that hands over one-cycle read and write strobes
// with an 8-bit index; video path, lock loop and ancillary parser sit outside
//
// Behaviour
// - bandwidth bit clear gives 650 kHz chroma
// - bandwidth bit set gives 1.3 MHz chroma
// - sync suppress outputs blanking instead of sync
// - burst suppress removes burst, chroma kept
// - luma suppress forces black luminance level
// - chroma suppress zeros chroma, burst kept
// - pedestal only on lines 23-262, 286-525
// - pedestal rescales gain to limit chroma
// - setup disabled means black equals blanking
// - all four suppress bits give DC blanking
// - lock enable locks synthesizer to reference
// - lock-lost flag reads one until locked
// - read-only field number reports current field
// - ancillary frequency load gated by valid flag
// - lock enabled lets lock circuit own values
// - ancillary phase load, else zero phase
// - ancillary timing used only when enabled
// - accept packets matching seven-bit identifier
// - identifier parity bit stored, not used
// - upper frequency bytes apply on low write
// - sixteen-bit phase offset relative to sync
// - port data bit maps to same pin
// - direction bit high drives, low inputs
// - pins 7,6,1,0 shared with other functions
`timescale 1ns/10ps
`include "vec_params.svh"

module vec_ctrl_regs #(
    parameter int PORT_W = 8
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_clk_en,
    input  wire logic                     i_reg_wr,
    input  wire logic                     i_reg_rd,
    input  wire logic [7:0]               i_reg_index,
    input  wire logic [7:0]               i_reg_wdata,
    output logic      [7:0]               o_reg_rdata,
    input  wire logic [9:0]               i_line_number,
    input  wire logic [2:0]               i_field_number,
    input  wire logic                     i_lock_achieved,
    input  wire logic [31:0]              i_lock_freq,
    input  wire logic [15:0]              i_lock_phase,
    input  wire vec_pkg::vec_anc_pkt_s    i_anc_pkt,
    input  wire logic [PORT_W-1:0]        i_port_pin,
    output logic      [PORT_W-1:0]        o_port_pin,
    output logic      [PORT_W-1:0]        o_port_pin_oe,
    output logic      [PORT_W-1:0]        o_port_pin_level,
    output vec_pkg::vec_video_ctrl_s      o_video_ctrl,
    output logic                          o_subcarrier_lock_enable,
    output logic      [31:0]              o_subcarrier_increment,
    output logic      [15:0]              o_subcarrier_phase,
    output logic      [15:0]              o_subcarrier_phase_offset,
    output logic                          o_anc_accept,
    output vec_pkg::vec_timing_s          o_timing
);

    function automatic logic in_range(input logic [9:0] v, input logic [9:0] lo,
                                      input logic [9:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic wr_hit(input logic wr, input logic [7:0] idx,
                                    input logic [7:0] target);
        wr_hit = wr && (idx == target);
    endfunction

    logic [7:0]        global_reg;
    logic [7:0]        video_out_reg;
    logic [2:0]        anc_enables_reg;
    logic [7:0]        anc_id_reg;
    logic [23:0]       freq_shadow_reg;
    logic [31:0]       freq_host_reg;
    logic [31:0]       freq_anc_reg;
    logic              freq_from_anc_reg;
    logic [15:0]       phase_anc_reg;
    logic [7:0]        phase_hi_reg;
    logic [7:0]        phase_lo_reg;
    logic [PORT_W-1:0] port_data_reg;
    logic [PORT_W-1:0] port_dir_reg;
    logic [PORT_W-1:0] pin_s1_reg;
    logic [PORT_W-1:0] pin_s2_reg;
    logic [PORT_W-1:0] pin_s3_reg;
    logic [PORT_W-1:0] pin_level_reg;
    logic              lock_lost_reg;
    logic [2:0]        field_reg;
    logic [2:0]        anc_field_reg;
    logic              anc_vflag_reg;

    logic lock_en;
    logic anc_match;
    logic setup_line;
    logic setup_fmt;
    logic [PORT_W-1:0] port_read;

    assign lock_en    = global_reg[`VEC_GLB_LOCK_EN];
    assign anc_match  = i_anc_pkt.valid && (i_anc_pkt.id[7:1] == anc_id_reg[7:1]);
    assign setup_line = in_range(i_line_number, `VEC_SETUP_A_FIRST, `VEC_SETUP_A_LAST) ||
                        in_range(i_line_number, `VEC_SETUP_B_FIRST, `VEC_SETUP_B_LAST);
    assign setup_fmt  = (global_reg[`VEC_GLB_FMT_HI:`VEC_GLB_FMT_LO] == `VEC_FMT_NTSC) ||
                        (global_reg[`VEC_GLB_FMT_HI:`VEC_GLB_FMT_LO] == `VEC_FMT_PALM);

    // host writes to the plain control registers
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            global_reg      <= `VEC_RST_BYTE;
            video_out_reg   <= `VEC_RST_BYTE;
            anc_enables_reg <= 3'h0;
            anc_id_reg      <= `VEC_RST_BYTE;
            phase_hi_reg    <= `VEC_RST_BYTE;
            phase_lo_reg    <= `VEC_RST_BYTE;
            port_data_reg   <= '0;
            port_dir_reg    <= '0;
        end else if (i_clk_en) begin
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_GLOBAL)) begin
                global_reg <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_VIDEO_OUT)) begin
                video_out_reg <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_ANC_CTRL)) begin
                // status and reserved bits ignore writes
                anc_enables_reg <= i_reg_wdata[`VEC_ANC_FREQ_EN:`VEC_ANC_TIMING_EN];
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_ANC_ID)) begin
                anc_id_reg <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_PHASE_HI)) begin
                phase_hi_reg <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_PHASE_LO)) begin
                phase_lo_reg <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_PORT_DATA)) begin
                port_data_reg <= i_reg_wdata[PORT_W-1:0];
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_PORT_DIR)) begin
                port_dir_reg <= i_reg_wdata[PORT_W-1:0];
            end
        end
    end

    // frequency word: upper bytes wait in the shadow until the low byte lands
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            freq_shadow_reg <= 24'(`VEC_RST_FREQ >> 8);
            freq_host_reg   <= `VEC_RST_FREQ;
        end else if (i_clk_en) begin
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_FREQ3)) begin
                freq_shadow_reg[23:16] <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_FREQ2)) begin
                freq_shadow_reg[15:8] <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_FREQ1)) begin
                freq_shadow_reg[7:0] <= i_reg_wdata;
            end
            if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_FREQ0)) begin
                freq_host_reg <= {freq_shadow_reg, i_reg_wdata};
            end
        end
    end

    // ancillary loads; a host low-byte write takes the word back from the stream unless a packet frequency load lands in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            freq_anc_reg      <= `VEC_RST_FREQ;
            freq_from_anc_reg <= 1'b0;
            phase_anc_reg     <= 16'h0000;
            anc_field_reg     <= 3'h0;
            anc_vflag_reg     <= 1'b0;
            o_anc_accept      <= 1'b0;
        end else if (i_clk_en) begin
            o_anc_accept <= anc_match;
            if (anc_match && anc_enables_reg[2] && i_anc_pkt.freq_valid && !lock_en) begin
                freq_anc_reg      <= i_anc_pkt.freq;
                freq_from_anc_reg <= 1'b1;
            end else if (wr_hit(i_reg_wr, i_reg_index, `VEC_IDX_FREQ0) ||
                         !anc_enables_reg[2]) begin
                freq_from_anc_reg <= 1'b0;
            end
            if (anc_match && anc_enables_reg[1] && i_anc_pkt.phase_valid && !lock_en) begin
                phase_anc_reg <= i_anc_pkt.phase;
            end
            if (anc_match && anc_enables_reg[0]) begin
                anc_field_reg <= i_anc_pkt.field;
                anc_vflag_reg <= i_anc_pkt.vflag;
            end
        end
    end

    // synthesizer controls; the lock loop overrides both words while enabled
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_subcarrier_lock_enable  <= 1'b0;
            o_subcarrier_increment    <= `VEC_RST_FREQ;
            o_subcarrier_phase        <= 16'h0000;
            o_subcarrier_phase_offset <= 16'h0000;
        end else if (i_clk_en) begin
            o_subcarrier_lock_enable  <= lock_en;
            o_subcarrier_increment    <= lock_en ? i_lock_freq :
                                         (freq_from_anc_reg ? freq_anc_reg : freq_host_reg);
            o_subcarrier_phase        <= lock_en ? i_lock_phase :
                                         (anc_enables_reg[1] ? phase_anc_reg : 16'h0000);
            o_subcarrier_phase_offset <= {phase_hi_reg, phase_lo_reg};
        end
    end

    // picture path controls
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_video_ctrl <= '0;
        end else if (i_clk_en) begin
            o_video_ctrl.chroma_wide  <= video_out_reg[`VEC_VO_CHROMA_BW];
            o_video_ctrl.sync_drop    <= video_out_reg[`VEC_VO_SYNC_SUP];
            o_video_ctrl.burst_drop   <= video_out_reg[`VEC_VO_BURST_SUP];
            o_video_ctrl.luma_black   <= video_out_reg[`VEC_VO_LUMA_SUP];
            o_video_ctrl.chroma_zero  <= video_out_reg[`VEC_VO_CHROMA_SUP];
            o_video_ctrl.dc_blank     <= &video_out_reg[`VEC_VO_SYNC_SUP:`VEC_VO_CHROMA_SUP];
            // format gate keeps PAL-B and friends free of setup
            o_video_ctrl.pedestal_on  <= video_out_reg[`VEC_VO_SETUP_EN] && setup_fmt &&
                                         setup_line;
            o_video_ctrl.gain_rescale <= video_out_reg[`VEC_VO_SETUP_EN] && setup_fmt;
        end
    end

    // status and timing source
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            lock_lost_reg <= 1'b1;
            field_reg     <= 3'h0;
            o_timing      <= '0;
        end else if (i_clk_en) begin
            lock_lost_reg    <= !i_lock_achieved;
            field_reg        <= anc_enables_reg[0] ? anc_field_reg : i_field_number;
            o_timing.use_anc <= anc_enables_reg[0];
            o_timing.field   <= anc_enables_reg[0] ? anc_field_reg : 3'h0;
            o_timing.vflag   <= anc_enables_reg[0] ? anc_vflag_reg : 1'b0;
        end
    end

    // port pins: a pin level counts once the second and third stages agree
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pin_s1_reg       <= '0;
            pin_s2_reg       <= '0;
            pin_s3_reg       <= '0;
            pin_level_reg    <= '0;
            o_port_pin       <= '0;
            o_port_pin_oe    <= '0;
            o_port_pin_level <= '0;
        end else if (i_clk_en) begin
            pin_s1_reg <= i_port_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            for (int i = 0; i < PORT_W; i++) begin
                if (pin_s2_reg[i] == pin_s3_reg[i]) begin
                    pin_level_reg[i] <= pin_s3_reg[i];
                end
            end
            o_port_pin       <= port_data_reg;
            o_port_pin_oe    <= port_dir_reg;
            // shared pads hand the filtered level to their other functions too
            o_port_pin_level <= pin_level_reg;
        end
    end

    assign port_read = (port_dir_reg & port_data_reg) | (~port_dir_reg & pin_level_reg);

    // read data; unmapped indices return zero
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_clk_en && i_reg_rd) begin
            case (i_reg_index)
                `VEC_IDX_GLOBAL:    o_reg_rdata <= global_reg;
                `VEC_IDX_VIDEO_OUT: o_reg_rdata <= video_out_reg;
                `VEC_IDX_ANC_CTRL:  o_reg_rdata <= {1'b0, lock_lost_reg, field_reg,
                                                    anc_enables_reg};
                `VEC_IDX_ANC_ID:    o_reg_rdata <= anc_id_reg;
                `VEC_IDX_FREQ3:     o_reg_rdata <= freq_shadow_reg[23:16];
                `VEC_IDX_FREQ2:     o_reg_rdata <= freq_shadow_reg[15:8];
                `VEC_IDX_FREQ1:     o_reg_rdata <= freq_shadow_reg[7:0];
                `VEC_IDX_FREQ0:     o_reg_rdata <= freq_host_reg[7:0];
                `VEC_IDX_PHASE_HI:  o_reg_rdata <= phase_hi_reg;
                `VEC_IDX_PHASE_LO:  o_reg_rdata <= phase_lo_reg;
                `VEC_IDX_PORT_DATA: o_reg_rdata <= 8'(port_read);
                `VEC_IDX_PORT_DIR:  o_reg_rdata <= 8'(port_dir_reg);
                default:            o_reg_rdata <= 8'h00;
            endcase
        end
    end

    property p_dc_blank;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && (&video_out_reg[4:1]) |=> o_video_ctrl.dc_blank;
    endproperty
    a_dc_blank: assert property (p_dc_blank) else $error("dc blank not raised");

    property p_pedestal_lines;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && (i_line_number < 10'h017 || (i_line_number > 10'h106 &&
        i_line_number < 10'h11E)) |=> !o_video_ctrl.pedestal_on;
    endproperty
    a_pedestal_lines: assert property (p_pedestal_lines)
        else $error("pedestal on a blank line");

    property p_no_setup;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && !video_out_reg[0] |=> !o_video_ctrl.pedestal_on && !o_video_ctrl.gain_rescale;
    endproperty
    a_no_setup: assert property (p_no_setup) else $error("setup without enable");

    property p_freq_double_buffer;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && i_reg_wr && i_reg_index == 8'h08 |=> $stable(freq_host_reg);
    endproperty
    a_freq_double_buffer: assert property (p_freq_double_buffer)
        else $error("upper byte applied early");

    property p_freq_commit;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && i_reg_wr && i_reg_index == 8'h0B |=>
        freq_host_reg == {$past(freq_shadow_reg), $past(i_reg_wdata)};
    endproperty
    a_freq_commit: assert property (p_freq_commit) else $error("low byte did not commit");

    property p_phase_zero;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && !lock_en && !anc_enables_reg[1] |=> o_subcarrier_phase == 16'h0000;
    endproperty
    a_phase_zero: assert property (p_phase_zero) else $error("phase not zero");

    property p_lock_owns;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && lock_en |=> o_subcarrier_increment == $past(i_lock_freq);
    endproperty
    a_lock_owns: assert property (p_lock_owns) else $error("lock loop not in control");

    property p_id_mismatch;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && i_anc_pkt.valid && i_anc_pkt.id[7:1] != anc_id_reg[7:1] |=> !o_anc_accept;
    endproperty
    a_id_mismatch: assert property (p_id_mismatch) else $error("foreign packet accepted");

    property p_pin_filter;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && pin_s2_reg != pin_s3_reg |=> pin_level_reg == $past(pin_level_reg);
    endproperty
    a_pin_filter: assert property (p_pin_filter) else $error("pin level moved on glitch");

    property p_reserved_read;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && i_reg_rd && i_reg_index == 8'h06 |=> !o_reg_rdata[7];
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("reserved bit set");

    property p_lock_lost;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en |=> lock_lost_reg == !$past(i_lock_achieved);
    endproperty
    a_lock_lost: assert property (p_lock_lost) else $error("lock status stale");

    property p_timing_off;
        @(posedge i_sys_clk) disable iff (i_sys_rst)
        i_clk_en && !anc_enables_reg[0] |=> o_timing == '0;
    endproperty
    a_timing_off: assert property (p_timing_off) else $error("ancillary timing leaked");

endmodule

// file: bench/vec_host_model.sv
// host model: issues register requests on the strobe bus, one at a time
// assumes one clock shared with the bank; requests change 1 ns after an edge
`timescale 1ns/10ps
module vec_host_model (
    input  wire logic       i_sys_clk,
    input  wire logic [7:0] i_reg_rdata,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic      [7:0] o_reg_index,
    output logic      [7:0] o_reg_wdata
);
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_index = 8'h00;
        o_reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg_wr    = 1'b1;
        o_reg_index = idx;
        o_reg_wdata = d;
        @(posedge i_sys_clk);
        #1;
        o_reg_wr    = 1'b0;
        // inverted after release so stale data never passes for a write
        o_reg_wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        @(posedge i_sys_clk);
        #1;
        o_reg_rd    = 1'b1;
        o_reg_index = idx;
        @(posedge i_sys_clk);
        #1;
        o_reg_rd    = 1'b0;
        o_reg_index = ~idx;
        @(posedge i_sys_clk);
        #1;
        d = i_reg_rdata;
    endtask
endmodule

// file: bench/vec_ctrl_regs_tb.sv
// self-checking bench for the encoder control bank
// assumes the bank, its package and the host model are compiled before it
`timescale 1ns/10ps
module vec_ctrl_regs_tb;
    logic                     clk = 1'b0;
    logic                     rst = 1'b1;
    logic                     wr, rd, acc, lock_en, lock = 1'b0;
    logic [7:0]               idx, wdata, rdata, pout, poe, plvl, ext = 8'h00;
    logic [7:0]               d, id, r, f [4];
    logic [9:0]               line = 10'h001;
    logic [2:0]               field = 3'h0;
    logic                     en = 1'b1;
    logic [31:0]              lfreq = 32'h00000000;
    logic [15:0]              lphase = 16'h0000;
    logic [31:0]              inc, e_inc, seed = 32'h00016746;
    logic [15:0]              ph, phoff, e_ph;
    vec_pkg::vec_anc_pkt_s    pkt = '0;
    vec_pkg::vec_video_ctrl_s vctl;
    vec_pkg::vec_timing_s     tim, e_tim;
    int                       num_errors = 0;
    int                       check_count = 0;
    logic [7:0]               rv [12] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h43, 8'hE0,
                                          8'hF8, 8'h3E, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [9:0]               lines [7] = '{10'h016, 10'h017, 10'h106, 10'h107,
                                            10'h11D, 10'h11E, 10'h20D};

    always #25 clk = ~clk;

    vec_host_model host (.i_sys_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_rd(rd),
                         .o_reg_index(idx), .o_reg_wdata(wdata));

    vec_ctrl_regs DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(en), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_index(idx), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_line_number(line), .i_field_number(field), .i_lock_achieved(lock),
        .i_lock_freq(lfreq), .i_lock_phase(lphase), .i_anc_pkt(pkt),
        .i_port_pin((pout & poe) | (ext & ~poe)), .o_port_pin(pout), .o_port_pin_oe(poe),
        .o_port_pin_level(plvl), .o_video_ctrl(vctl), .o_subcarrier_lock_enable(lock_en),
        .o_subcarrier_increment(inc), .o_subcarrier_phase(ph),
        .o_subcarrier_phase_offset(phoff), .o_anc_accept(acc), .o_timing(tim));

    function automatic logic [31:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [7:0] exp_vid(input logic [7:0] b, input logic [9:0] ln,
                                           input logic [1:0] fm);
        logic ped;
        logic fmt_ok;
        // setup only in the two formats that carry it
        fmt_ok = (fm == 2'h0) || (fm == 2'h2);
        ped = b[0] && fmt_ok &&
              ((ln >= 10'h017 && ln <= 10'h106) || (ln >= 10'h11E && ln <= 10'h20D));
        return {b[5], b[4], b[3], b[2], b[1], &b[4:1], ped, b[0] && fmt_ok};
    endfunction

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic stop_test();
        if (num_errors == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        check("increment", inc, 32'h43E0F83E);
        for (int i = 0; i < 12; i++) begin
            host.rd(8'h04 + i[7:0], d);
            check("reset value", d, rv[i]);
        end
        // all four suppress bits together first, then random settings
        for (int k = 0; k < 21; k++) begin
            d = k ? 8'(rnd()) : 8'h1F;
            line = lines[k % 7];
            host.wr(8'h04, 8'(k % 4));
            host.wr(8'h05, d);
            settle();
            check("video control", vctl, exp_vid(d, line, 2'(k % 4)));
        end
        for (int i = 0; i < 4; i++) f[i] = 8'(rnd());
        for (int i = 0; i < 3; i++) host.wr(8'h08 + i[7:0], f[i]);
        settle();
        check("increment held", inc, 32'h43E0F83E);
        host.wr(8'h0B, f[3]);
        settle();
        check("increment", inc, {f[0], f[1], f[2], f[3]});
        host.wr(8'h0C, f[1]);
        host.wr(8'h0D, f[2]);
        settle();
        check("phase offset", phoff, {f[1], f[2]});
        field = 3'(rnd());
        lock = 1'b1;
        d = 8'(rnd()) | 8'h80;
        host.wr(8'h06, d & 8'hFE);
        host.rd(8'h06, r);
        check("anc status", r, {2'b00, field, d[2:1], 1'b0});
        id = 8'(rnd());
        host.wr(8'h07, id);
        host.rd(8'h07, r);
        check("packet id", r, id);
        host.wr(8'h06, 8'h07);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            #1;
            pkt = {1'b1, id ^ (k ? 8'h02 : 8'h01), rnd(), 1'b1, 16'(rnd()), 1'b1, 4'(rnd())};
            @(posedge clk);
            #1;
            pkt.valid = 1'b0;
            check("accept", acc, k == 0);
            if (k == 0) begin
                e_inc = pkt.freq;
                e_ph = pkt.phase;
                e_tim = {1'b1, pkt.field, pkt.vflag};
            end
            @(posedge clk);
            #1;
            check("anc freq", inc, e_inc);
            check("anc phase", ph, e_ph);
            check("anc timing", tim, e_tim);
        end
        host.wr(8'h06, 8'h00);
        settle();
        check("zero phase", ph, 16'h0000);
        check("timing off", tim, 5'h00);
        check("host freq", inc, {f[0], f[1], f[2], f[3]});
        // enables already cleared, as firmware must before locking
        lfreq = rnd();
        lphase = 16'(rnd());
        host.wr(8'h04, 8'h40);
        settle();
        check("lock enable", lock_en, 1'b1);
        check("lock freq", inc, lfreq);
        check("lock phase", ph, lphase);
        for (int k = 0; k < 4; k++) begin
            f[0] = 8'(rnd());
            f[1] = 8'(rnd());
            ext = 8'(rnd());
            host.wr(8'h0E, f[0]);
            host.wr(8'h0F, f[1]);
            settle();
            check("pin drive", pout, f[0]);
            check("pin enable", poe, f[1]);
            repeat (6) @(posedge clk);
            #1;
            check("pin level", plvl, (f[0] & f[1]) | (ext & ~f[1]));
            host.rd(8'h0E, r);
            check("port read", r, (f[0] & f[1]) | (ext & ~f[1]));
        end
        // a write while the enable is low must leave the bank untouched
        en = 1'b0;
        host.wr(8'h0E, ~f[0]);
        en = 1'b1;
        settle();
        check("frozen write", pout, f[0]);
        host.wr(8'h10, 8'(rnd()));
        host.rd(8'h10, r);
        check("unmapped read", r, 8'h00);
        stop_test();
    end
endmodule
